// [rtl/ee_pkg.sv]
// Shared constants and types for the two-wire serial EEPROM link
package ee_pkg;

	// =====================================================================
	// Word and address layout
	localparam int         BYTE_W     = 8;
	localparam int         ADDR_W     = 15;
	localparam int         PAGE_W     = 6;
	localparam int         PAGE_BYTES = 64;
	localparam logic [3:0] DEV_TYPE   = 4'ha;
	localparam int         TYPE_LSB   = 4;
	localparam int         CS_LSB     = 1;
	localparam int         RW_BIT     = 0;
	localparam logic [3:0] LAST_BIT   = 4'h7;
	localparam logic [3:0] ACK_SLOT   = 4'h8;

	// =====================================================================
	// Timing
	localparam int CLK_MHZ        = 100;
	localparam int T_WR_US        = 5000;
	localparam int WR_CYCLES      = T_WR_US * CLK_MHZ;
	localparam int SCL_QUARTER_NS = 80;
	localparam int SCL_QUARTER    = (SCL_QUARTER_NS * CLK_MHZ) / 1000;

	// =====================================================================
	// Reset values
	localparam logic SCL_IDLE      = 1'b1;
	localparam logic LINK_QUIET    = 1'b1;

	// =====================================================================
	// Host command set
	typedef enum logic [1:0] {CMD_START, CMD_STOP, CMD_WRITE, CMD_READ} ee_cmd_e;

endpackage

// [rtl/ee_link_if.sv]
// Two-wire link between the bus master and the EEPROM end
`timescale 1ns/100ps
interface ee_link_if;
	logic scl;
	logic host_sda_o;
	logic host_sda_oe;
	logic dev_sda_o;
	logic dev_sda_oe;
	logic sda;

	// Open-drain wire with external pull-up: high unless someone pulls low
	assign sda = ~((host_sda_oe & ~host_sda_o) | (dev_sda_oe & ~dev_sda_o));

	modport host (output scl, output host_sda_o, output host_sda_oe, input sda);
	modport dev  (input scl, input sda, output dev_sda_o, output dev_sda_oe);
endinterface

// [rtl/ee_sync.sv]
// Two-stage level synchroniser
`timescale 1ns/100ps
module ee_sync
(
	input  wire logic clk_i,
	input  wire logic nrst_i,
	input  wire logic d_i,
	output logic      q_o
);
	logic meta_r;

	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			meta_r <= 1'b0;
			q_o    <= 1'b0;
		end
		else
		begin
			meta_r <= d_i;
			q_o    <= meta_r;
		end
	end
endmodule

// [rtl/ee_host.sv]
// Two-wire bus master end: byte-level START, STOP, WRITE and READ commands
`timescale 1ns/100ps
module ee_host
(
	input  wire logic            clk_i,
	input  wire logic            nrst_i,
	ee_link_if.host              link,
	input  wire logic            cmd_valid_i,
	input  ee_pkg::ee_cmd_e      cmd_i,
	input  wire logic [7:0]      cmd_data_i,
	input  wire logic            cmd_mack_i,
	output logic                 cmd_ready_o,
	output logic                 rsp_valid_o,
	output logic [7:0]           rsp_data_o,
	output logic                 rsp_nack_o
);
	localparam int QW = $clog2(ee_pkg::SCL_QUARTER + 1);

	typedef enum {H_IDLE, H_START, H_STOP, H_BYTE} ee_hst_e;

	ee_hst_e         st_r;
	logic [QW-1:0]   q_r;
	logic [1:0]      ph_r;
	logic [3:0]      bit_r;
	logic [7:0]      tx_r;
	logic            rd_r;
	logic            mack_r;
	logic            sda_s;
	logic            tick;
	logic            drv_low;
	logic            last_q;

	// =====================================================================
	// Clock divider and sampled data line
	ee_sync u_sda
	(
		.clk_i  (clk_i),
		.nrst_i (nrst_i),
		.d_i    (link.sda),
		.q_o    (sda_s)
	);

	assign tick   = (q_r == QW'(ee_pkg::SCL_QUARTER - 1));
	assign last_q = (st_r != H_BYTE) || (bit_r == ee_pkg::ACK_SLOT);

	// Level set up in quarter 0, while the clock is low
	assign drv_low = (st_r == H_STOP) ? 1'b1 :                                     // R06
	                 (st_r == H_START) ? 1'b0 :
	                 (bit_r != ee_pkg::ACK_SLOT) ? (!rd_r && !tx_r[3'(4'd7 - bit_r)]) :
	                 (rd_r && mack_r);                                             // R19

	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			q_r <= '0;
		else
			q_r <= tick ? '0 : q_r + QW'(1);
	end

	// =====================================================================
	// Command sequencer: four quarters per bit
	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			st_r             <= H_IDLE;
			ph_r             <= 2'h0;
			bit_r            <= 4'h0;
			tx_r             <= 8'h00;
			rd_r             <= 1'b0;
			mack_r           <= 1'b0;
			link.scl         <= ee_pkg::SCL_IDLE;
			link.host_sda_oe <= 1'b0;
			link.host_sda_o  <= 1'b0;
			cmd_ready_o      <= 1'b1;
			rsp_valid_o      <= 1'b0;
			rsp_data_o       <= 8'h00;
			rsp_nack_o       <= 1'b0;
		end
		else if (st_r == H_IDLE)
		begin
			rsp_valid_o <= 1'b0;
			if (cmd_valid_i)
			begin
				st_r        <= (cmd_i == ee_pkg::CMD_START) ? H_START :
				               (cmd_i == ee_pkg::CMD_STOP) ? H_STOP : H_BYTE;
				rd_r        <= (cmd_i == ee_pkg::CMD_READ);
				tx_r        <= cmd_data_i;
				mack_r      <= cmd_mack_i;
				bit_r       <= 4'h0;
				ph_r        <= 2'h0;
				cmd_ready_o <= 1'b0;
			end
		end
		else if (tick)
		begin
			ph_r <= ph_r + 2'h1;
			case (ph_r)
				2'h0:
				begin
					link.scl         <= 1'b0;
					link.host_sda_oe <= drv_low;                                   // R04
				end
				2'h1:
					link.scl <= 1'b1;
				2'h2:
				begin
					if (st_r == H_START)
						link.host_sda_oe <= 1'b1;                                  // R05 R21
					else if (st_r == H_STOP)
						link.host_sda_oe <= 1'b0;                                  // R06
					else if (bit_r != ee_pkg::ACK_SLOT)
						rsp_data_o <= {rsp_data_o[6:0], sda_s};
					else
						rsp_nack_o <= sda_s;                                       // R08
				end
				default:
				begin
					// A stop leaves the clock high so the bus reads idle
					if (st_r != H_STOP)
						link.scl <= 1'b0;
					if (last_q)
					begin
						st_r        <= H_IDLE;
						cmd_ready_o <= 1'b1;
						rsp_valid_o <= 1'b1;
					end
					else
						bit_r <= bit_r + 4'h1;                                     // R10 R13 R15
				end
			endcase
		end
	end
endmodule

// [rtl/ee_dev.sv]
// Two-wire serial EEPROM end: link decoder, page buffer and self-timed program
// Summary of operation
// R01: Sample on clock rise, drive after fall
// R02: Write-protect high blocks programming, reads unaffected
// R03: 64-byte pages, 14- or 15-bit addresses
// R04: Data changes only while clock low
// R05: Fall of data with clock high starts
// R06: Rise of data with clock high stops
// R07: Standby after read stop or programming end
// R08: Acknowledge each received byte on ninth clock
// R09: Standby after power-up
// R10: Address word must start with 1010
// R11: Chip-select bits must match, else standby
// R12: Eighth address bit picks read or write
// R13: Byte write: two address bytes, data, stop
// R14: Programming ignores the bus until done
// R15: Page write carries up to 64 bytes
// R16: Only low six address bits increment
// R17: No address acknowledge while programming
// R18: Counter holds last address plus one
// R19: Master acks to continue, nacks then stops
// R20: Sequential read wraps at top of array
// R21: Dummy write then new start reads
// R22: Release data line unless driving low
// R23: Small variant ignores unused address bits
`timescale 1ns/100ps
module ee_dev
#(
	parameter int MEM_ABITS = ee_pkg::ADDR_W,
	parameter int WR_CYCLES = ee_pkg::WR_CYCLES
)
(
	input  wire logic clk_i,
	input  wire logic nrst_i,
	ee_link_if.dev    link,
	input  wire logic chip_select_bit2_i,
	input  wire logic chip_select_bit1_i,
	input  wire logic chip_select_bit0_i,
	input  wire logic wp_i,
	output logic      standby_o,
	output logic      write_busy_o
);
	localparam int                       TW       = $clog2(WR_CYCLES + 1);
	localparam logic [ee_pkg::ADDR_W-1:0] ADDR_MSK = ee_pkg::ADDR_W'((1 << MEM_ABITS) - 1);

	typedef enum {S_IDLE, S_DEV, S_AHI, S_ALO, S_WDATA, S_RDATA} ee_lst_e;
	typedef enum {C_IDLE, C_PROG} ee_cst_e;

	// Array, written only by the program sequencer
	logic [7:0] mem_r [0:(1 << MEM_ABITS) - 1];                                   // R03

	// Link-clock side
	ee_lst_e                       st_r;
	logic [3:0]                    cnt_r;
	logic [7:0]                    sh_r;
	logic [7:0]                    tx_r;
	logic                          ack_r;
	logic                          rw_r;
	logic                          pend_r;
	logic                          first_r;
	logic [ee_pkg::ADDR_W-1:0]     addr_r;
	logic [ee_pkg::ADDR_W-ee_pkg::PAGE_W-1:0] page_r;
	logic [7:0]                    buf_r [0:ee_pkg::PAGE_BYTES-1];
	logic [ee_pkg::PAGE_BYTES-1:0] mask_r;
	logic                          start_tgl_r;
	logic                          start_seen_r;
	logic                          stop_tgl_r;
	logic                          busy_l;

	// Local clock side
	ee_cst_e                       cst_r;
	logic [TW-1:0]                 tmr_r;
	logic                          start_s;
	logic                          stop_s;
	logic                          start_d_r;
	logic                          stop_d_r;
	logic                          pend_s;
	logic                          wp_s;
	logic                          quiet_r;

	logic                          start_new;
	logic                          ack_clk;
	logic                          byte_done;
	logic [7:0]                    rx_byte;
	logic                          dev_match;
	logic [ee_pkg::ADDR_W-1:0]     addr_inc;
	logic [ee_pkg::ADDR_W-1:0]     addr_pg;
	logic                          rd_bit;
	logic                          start_evt;
	logic                          stop_evt;
	logic [ee_pkg::ADDR_W-1:0]     wr_addr;

	// =====================================================================
	// Bus conditions, caught on data-line edges while the clock is high
	// Toggles keep them free of any other clock; the stop must be seen
	// by the local clock because the link clock stands still after it.
	always_ff @(negedge link.sda or negedge nrst_i)
	begin
		if (!nrst_i)
			start_tgl_r <= 1'b0;
		else if (link.scl)
			start_tgl_r <= ~start_tgl_r;                                           // R05
	end

	always_ff @(posedge link.sda or negedge nrst_i)
	begin
		if (!nrst_i)
			stop_tgl_r <= 1'b0;
		else if (link.scl)
			stop_tgl_r <= ~stop_tgl_r;                                             // R06
	end

	// =====================================================================
	// Link decode
	assign start_new = (start_tgl_r != start_seen_r);
	assign ack_clk   = (cnt_r == ee_pkg::ACK_SLOT);
	assign byte_done = (cnt_r == ee_pkg::LAST_BIT) && (st_r != S_RDATA);
	assign rx_byte   = {sh_r[6:0], link.sda};                                     // R01 R04
	assign dev_match = (rx_byte[7:ee_pkg::TYPE_LSB] == ee_pkg::DEV_TYPE) &&       // R10
	                   (rx_byte[ee_pkg::TYPE_LSB-1:ee_pkg::CS_LSB] ==
	                    {chip_select_bit2_i, chip_select_bit1_i, chip_select_bit0_i}) && // R11
	                   !busy_l;                                                    // R17 R14
	assign addr_inc  = (addr_r + ee_pkg::ADDR_W'(1)) & ADDR_MSK;                   // R20 R23
	assign addr_pg   = {addr_r[ee_pkg::ADDR_W-1:ee_pkg::PAGE_W],
	                    addr_r[ee_pkg::PAGE_W-1:0] + ee_pkg::PAGE_W'(1)};          // R16
	assign rd_bit    = tx_r[3'(4'd7 - cnt_r)];

	ee_sync u_busy
	(
		.clk_i  (link.scl),
		.nrst_i (nrst_i),
		.d_i    (write_busy_o),
		.q_o    (busy_l)
	);

	always_ff @(posedge link.scl or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			st_r         <= S_IDLE;
			cnt_r        <= 4'h0;
			sh_r         <= 8'h00;
			tx_r         <= 8'h00;
			ack_r        <= 1'b0;
			rw_r         <= 1'b0;
			pend_r       <= 1'b0;
			first_r      <= 1'b0;
			addr_r       <= '0;
			page_r       <= '0;
			mask_r       <= '0;
			start_seen_r <= 1'b0;
		end
		else if (start_new)
		begin
			// This rising edge already carries the first address bit
			start_seen_r <= start_tgl_r;
			st_r         <= S_DEV;
			cnt_r        <= 4'h1;
			sh_r         <= {7'h00, link.sda};
			ack_r        <= 1'b0;
			pend_r       <= 1'b0;                                                  // R21
			first_r      <= 1'b1;
		end
		else if (st_r != S_IDLE)
		begin
			cnt_r <= ack_clk ? 4'h0 : cnt_r + 4'h1;
			sh_r  <= rx_byte;
			if (byte_done)
			begin
				ack_r <= (st_r != S_DEV) || dev_match;                             // R08
				case (st_r)
					S_DEV:
					begin
						rw_r <= rx_byte[ee_pkg::RW_BIT];                           // R12
						if (!dev_match)
							st_r <= S_IDLE;                                        // R11 R17
					end
					S_AHI:
						addr_r[ee_pkg::ADDR_W-1:8] <= rx_byte[ee_pkg::ADDR_W-9:0] &
						                              ADDR_MSK[ee_pkg::ADDR_W-1:8]; // R23
					S_ALO:
					begin
						// Page bits 7:6 arrive in this byte, not in the stored address
						addr_r[7:0] <= rx_byte;
						page_r      <= {addr_r[ee_pkg::ADDR_W-1:8], rx_byte[7:ee_pkg::PAGE_W]};
					end
					S_WDATA:
					begin
						pend_r  <= 1'b1;                                           // R13 R15
						first_r <= 1'b0;
						addr_r  <= addr_pg;                                        // R16 R18
						mask_r  <= (first_r ? '0 : mask_r) |
						           (ee_pkg::PAGE_BYTES'(1) << addr_r[ee_pkg::PAGE_W-1:0]);
					end
					default:
						st_r <= S_IDLE;
				endcase
			end
			if (ack_clk)
			begin
				ack_r <= 1'b0;
				case (st_r)
					S_DEV:
					begin
						st_r <= rw_r ? S_RDATA : S_AHI;
						if (rw_r)
						begin
							tx_r   <= mem_r[addr_r];                               // R18
							addr_r <= addr_inc;                                    // R20
						end
					end
					S_AHI:
						st_r <= S_ALO;
					S_ALO:
						st_r <= S_WDATA;
					S_RDATA:
					begin
						if (!link.sda)
						begin
							tx_r   <= mem_r[addr_r];                               // R19
							addr_r <= addr_inc;                                    // R20
						end
						else
							st_r <= S_IDLE;                                        // R19
					end
					default:
						st_r <= st_r;
				endcase
			end
		end
	end

	// Page buffer; read by the program sequencer only while the link is shut out
	always_ff @(posedge link.scl)
	begin
		if (byte_done && (st_r == S_WDATA) && !start_new)
			buf_r[addr_r[ee_pkg::PAGE_W-1:0]] <= rx_byte;                         // R15
	end

	// Driven low only for an acknowledge or a zero read bit
	always_ff @(negedge link.scl or negedge nrst_i)
	begin
		if (!nrst_i)
			link.dev_sda_oe <= 1'b0;
		else
			link.dev_sda_oe <= ack_r ||                                            // R08
			                   ((st_r == S_RDATA) && !ack_clk && !rd_bit);         // R01 R22
	end

	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			link.dev_sda_o <= 1'b0;
		else
			link.dev_sda_o <= 1'b0;                                                // R22
	end

	// =====================================================================
	// Self-timed programming on the local clock
	ee_sync u_start
	(
		.clk_i  (clk_i),
		.nrst_i (nrst_i),
		.d_i    (start_tgl_r),
		.q_o    (start_s)
	);

	ee_sync u_stop
	(
		.clk_i  (clk_i),
		.nrst_i (nrst_i),
		.d_i    (stop_tgl_r),
		.q_o    (stop_s)
	);

	ee_sync u_pend
	(
		.clk_i  (clk_i),
		.nrst_i (nrst_i),
		.d_i    (pend_r),
		.q_o    (pend_s)
	);

	ee_sync u_wp
	(
		.clk_i  (clk_i),
		.nrst_i (nrst_i),
		.d_i    (wp_i),
		.q_o    (wp_s)
	);

	assign start_evt = (start_s != start_d_r);
	assign stop_evt  = (stop_s != stop_d_r);
	assign wr_addr   = {page_r, tmr_r[ee_pkg::PAGE_W-1:0]} & ADDR_MSK;           // R23

	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			cst_r        <= C_IDLE;
			tmr_r        <= '0;
			start_d_r    <= 1'b0;
			stop_d_r     <= 1'b0;
			quiet_r      <= ee_pkg::LINK_QUIET;                                    // R09
			standby_o    <= 1'b0;
			write_busy_o <= 1'b0;
		end
		else
		begin
			start_d_r <= start_s;
			stop_d_r  <= stop_s;
			if (start_evt)
				quiet_r <= 1'b0;
			else if (stop_evt)
				quiet_r <= 1'b1;                                                   // R07
			standby_o <= quiet_r && (cst_r == C_IDLE);                             // R07 R09
			case (cst_r)
				C_IDLE:
				begin
					tmr_r <= '0;
					if (stop_evt && pend_s && !wp_s)                               // R02 R13
					begin
						cst_r        <= C_PROG;
						write_busy_o <= 1'b1;                                      // R14
					end
				end
				C_PROG:
				begin
					tmr_r <= tmr_r + TW'(1);
					if (tmr_r == TW'(WR_CYCLES - 1))
					begin
						cst_r        <= C_IDLE;
						write_busy_o <= 1'b0;                                      // R07 R17
					end
				end
				default:
					cst_r <= C_IDLE;
			endcase
		end
	end

	// Copy takes the first page-size cycles of the program time
	always_ff @(posedge clk_i)
	begin
		if ((cst_r == C_PROG) && (tmr_r < TW'(ee_pkg::PAGE_BYTES)) &&
		    mask_r[tmr_r[ee_pkg::PAGE_W-1:0]])
			mem_r[wr_addr] <= buf_r[tmr_r[ee_pkg::PAGE_W-1:0]];                  // R16
	end
endmodule

// [dv/ee_link_monitor.sv]
// Concurrent checks on the two-wire link and the EEPROM status flags
`timescale 1ns/100ps
module ee_link_monitor
#(
	parameter int WR_CYCLES = 600
)
(
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic scl,
	input wire logic host_sda_o,
	input wire logic host_sda_oe,
	input wire logic dev_sda_o,
	input wire logic dev_sda_oe,
	input wire logic sda,
	input wire logic chip_select_bit2_i,
	input wire logic chip_select_bit1_i,
	input wire logic chip_select_bit0_i,
	input wire logic write_busy_o,
	input wire logic standby_o
);
	// =====================================================================
	// Bus event tracking, oversampled on the local clock
	logic       scl_q;
	logic       sda_q;
	logic       first_r;
	logic       rd_r;
	logic [3:0] bit_r;
	logic [7:0] sh_r;
	int         busy_r;
	wire        start_w = scl && scl_q && sda_q && !sda;
	wire        stop_w  = scl && scl_q && !sda_q && sda;
	wire        rise_w  = scl && !scl_q;
	wire        data_w  = rd_r && !first_r;
	wire  [2:0] cs_w    = {chip_select_bit2_i, chip_select_bit1_i, chip_select_bit0_i};

	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end
		else
		begin
			scl_q <= scl;
			sda_q <= sda;
		end
	end

	// A repeated START also counts one rise; the START itself clears it
	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			bit_r   <= 4'h0;
			first_r <= 1'b0;
			rd_r    <= 1'b0;
			sh_r    <= 8'h00;
		end
		else if (start_w)
		begin
			bit_r   <= 4'h0;
			first_r <= 1'b1;
			rd_r    <= 1'b0;
		end
		else if (rise_w)
		begin
			bit_r   <= (bit_r == 4'h8) ? 4'h0 : bit_r + 4'h1;
			first_r <= first_r && (bit_r != 4'h8);
			sh_r    <= {sh_r[6:0], sda};
			rd_r    <= (first_r && bit_r == 4'h7) ? sda : rd_r;
		end
	end

	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			busy_r <= 0;
		else
			busy_r <= write_busy_o ? busy_r + 1 : 0;
	end

	// =====================================================================
	// Assertions
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!nrst_i);

	sequence s_addr_ack;
		$rose(dev_sda_oe) && first_r && bit_r == 4'h8;
	endsequence
	property p_addr_match;
		s_addr_ack |-> sh_r[7:4] == ee_pkg::DEV_TYPE && sh_r[3:1] == cs_w && !write_busy_o;
	endproperty
	a_addr_match: assert property (p_addr_match) else $error("ack without match");
	property p_ack_slot;
		$rose(dev_sda_oe) && !data_w |-> bit_r == 4'h8;
	endproperty
	a_ack_slot: assert property (p_ack_slot) else $error("ack outside slot");
	property p_ack_release;
		$fell(dev_sda_oe) && !data_w |-> bit_r == 4'h0;
	endproperty
	a_ack_release: assert property (p_ack_release) else $error("ack length wrong");
	property p_master_slot;
		data_w && bit_r == 4'h8 && !scl |-> !dev_sda_oe;
	endproperty
	a_master_slot: assert property (p_master_slot) else $error("line held in master slot");
	property p_oe_scl_low;
		$changed(dev_sda_oe) |-> !scl;
	endproperty
	a_oe_scl_low: assert property (p_oe_scl_low) else $error("data moved with clock high");
	property p_open_drain;
		dev_sda_oe |-> !dev_sda_o;
	endproperty
	a_open_drain: assert property (p_open_drain) else $error("line driven high");
	property p_busy_len;
		$fell(write_busy_o) |-> busy_r >= WR_CYCLES - 1 && busy_r <= WR_CYCLES + 1;
	endproperty
	a_busy_len: assert property (p_busy_len) else $error("program time wrong");
	property p_busy_standby;
		write_busy_o |-> !standby_o;
	endproperty
	a_busy_standby: assert property (p_busy_standby) else $error("standby while busy");
	property p_standby_after;
		$fell(write_busy_o) |-> ##[0:2] standby_o;
	endproperty
	a_standby_after: assert property (p_standby_after) else $error("no standby");
	property p_read_stop;
		stop_w && rd_r && !write_busy_o |-> ##[1:8] standby_o;
	endproperty
	a_read_stop: assert property (p_read_stop) else $error("no standby after read");
endmodule

// [dv/serial_eeprom_bus_slave_tb_top.sv]
// Testbench: host and EEPROM ends joined, checked against a byte model
`timescale 1ns/100ps
module serial_eeprom_bus_slave_tb_top;
	localparam int WRC = 600;
	logic            clk_i, nrst_i, cmd_valid, cmd_mack, wp, cmd_ready;
	logic            rsp_valid, rsp_nack, standby, busy;
	logic [2:0]      cs;
	logic [7:0]      cmd_data, rsp_data;
	logic [14:0]     a;
	ee_pkg::ee_cmd_e cmd;
	int              fails, n_checks, ctr;
	logic [7:0]      mem [int];

	ee_link_if link();
	ee_host i_ee_host (.clk_i(clk_i), .nrst_i(nrst_i), .link(link), .cmd_valid_i(cmd_valid),
		.cmd_i(cmd), .cmd_data_i(cmd_data), .cmd_mack_i(cmd_mack), .cmd_ready_o(cmd_ready),
		.rsp_valid_o(rsp_valid), .rsp_data_o(rsp_data), .rsp_nack_o(rsp_nack));
	ee_dev #(.MEM_ABITS(15), .WR_CYCLES(WRC)) i_ee_dev (.clk_i(clk_i), .nrst_i(nrst_i),
		.link(link), .chip_select_bit2_i(cs[2]), .chip_select_bit1_i(cs[1]),
		.chip_select_bit0_i(cs[0]), .wp_i(wp), .standby_o(standby), .write_busy_o(busy));
	ee_link_monitor #(.WR_CYCLES(WRC)) i_ee_link_monitor (.clk_i(clk_i), .nrst_i(nrst_i),
		.scl(link.scl), .host_sda_o(link.host_sda_o), .host_sda_oe(link.host_sda_oe),
		.dev_sda_o(link.dev_sda_o), .dev_sda_oe(link.dev_sda_oe), .sda(link.sda),
		.chip_select_bit2_i(cs[2]), .chip_select_bit1_i(cs[1]), .chip_select_bit0_i(cs[0]),
		.write_busy_o(busy), .standby_o(standby));

	// =====================================================================
	// Compare and report
	task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
		n_checks++;
		if (g !== e)
		begin
			fails++;
			$display("unexpected %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic chkb(string nm, logic e, logic g);
		n_checks++;
		if (g !== e)
		begin
			fails++;
			$display("unexpected %s exp %b got %b", nm, e, g);
		end
	endtask
	task automatic results();
		$display("checks %0d fails %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// =====================================================================
	// Host commands; called only right after a clock edge with ready high
	task automatic op(ee_pkg::ee_cmd_e c, logic [7:0] d = 8'h00, logic m = 1'b0);
		int n;
		n = 0;
		cmd_valid <= 1'b1;
		cmd <= c;
		cmd_data <= d;
		cmd_mack <= m;
		@(posedge clk_i);
		cmd_valid <= 1'b0;
		do
		begin
			@(posedge clk_i);
			n++;
		end
		while (rsp_valid !== 1'b1 && n < 400);
		if (n >= 400)
		begin
			fails++;
			results();
		end
	endtask
	task automatic wb(logic [7:0] d, logic e);
		op(ee_pkg::CMD_WRITE, d);
		chkb("nack", e, rsp_nack);
	endtask
	function automatic logic [7:0] da(logic rw);
		return {ee_pkg::DEV_TYPE, cs, rw};
	endfunction
	task automatic seta(logic [14:0] wa);
		op(ee_pkg::CMD_START);
		wb(da(1'b0), 1'b0);
		wb({1'b0, wa[14:8]}, 1'b0);
		wb(wa[7:0], 1'b0);
	endtask
	task automatic poll(logic e);
		op(ee_pkg::CMD_START);
		wb(da(1'b0), e);
		op(ee_pkg::CMD_STOP);
	endtask

	// Polls once inside the program time, then again once it is over
	task automatic wr(logic [14:0] wa, int n);
		logic [7:0] q [$];
		seta(wa);
		for (int i = 0; i < n; i++)
		begin
			q.push_back(8'($urandom));
			wb(q[i], 1'b0);
		end
		op(ee_pkg::CMD_STOP);
		if (wp !== 1'b1)
			foreach (q[i]) mem[{wa[14:6], 6'(wa[5:0] + i)}] = q[i];
		ctr = {wa[14:6], 6'(wa[5:0] + n)};
		repeat (8) @(posedge clk_i);
		chkb("busy", !wp, busy);
		if (wp !== 1'b1)
		begin
			poll(1'b1);
			for (int k = 0; busy !== 1'b0 && k < WRC; k++)
				@(posedge clk_i);
			if (busy !== 1'b0)
			begin
				fails++;
				results();
			end
			repeat (3) @(posedge clk_i);
			chkb("standby", 1'b1, standby);
			poll(1'b0);
		end
	endtask
	task automatic rd(logic [14:0] ra, int n, bit rnd);
		if (rnd)
		begin
			seta(ra);
			ctr = ra;
		end
		op(ee_pkg::CMD_START);
		wb(da(1'b1), 1'b0);
		for (int i = 0; i < n; i++)
		begin
			op(ee_pkg::CMD_READ, 8'h00, i < n - 1);
			if (mem.exists(ctr)) chk("data", mem[ctr], rsp_data);
			ctr = (ctr + 1) % 32768;
		end
		op(ee_pkg::CMD_STOP);
		repeat (8) @(posedge clk_i);
		chkb("standby", 1'b1, standby);
	endtask

	// =====================================================================
	// Main sequence
	initial
	begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end
	initial
	begin
		void'($urandom(32'hcad7));
		nrst_i = 1'b0;
		cmd_valid = 1'b0;
		cmd = ee_pkg::CMD_START;
		cmd_data = 8'h00;
		cmd_mack = 1'b0;
		wp = 1'b0;
		cs = 3'($urandom);
		repeat (16) @(posedge clk_i);
		nrst_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		chkb("standby", 1'b1, standby);
		chkb("busy", 1'b0, busy);
		$display("test reset done");
		op(ee_pkg::CMD_START);
		wb({4'hb, cs, 1'b0}, 1'b1);
		op(ee_pkg::CMD_STOP);
		op(ee_pkg::CMD_START);
		wb({ee_pkg::DEV_TYPE, ~cs, 1'b0}, 1'b1);
		op(ee_pkg::CMD_STOP);
		chkb("sda", 1'b1, link.sda);
		$display("test refuse done");
		a = 15'($urandom);
		wr(a, 1);
		rd(a, 1, 1'b1);
		$display("test byte done");
		a = {a[14:6], 6'h3e};
		wr(a, 66);
		rd(a, 1, 1'b0);
		rd({a[14:6], 6'h00}, 64, 1'b1);
		$display("test page done");
		wp <= 1'b1;
		wr(a, 1);
		wp <= 1'b0;
		rd(a, 1, 1'b1);
		$display("test protect done");
		wr(15'h7fff, 1);
		wr(15'h0000, 1);
		rd(15'h7fff, 2, 1'b1);
		$display("test wrap done");
		results();
	end
endmodule
